/* src/alu_cfg.svh */
// Encodings, field positions and constant masks of the subtract and compare datapath
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

// Register and operand widths
`define REG_W 24
`define REG_ADDR_W 3
`define INSTR_W 16

// Instruction field positions (bit 0 of the format is the word's MSB)
`define FMT_RI_BIT 15
`define RI_OPC_HI 15
`define RI_OPC_LO 11
`define RI_REG_HI 10
`define RI_REG_LO 9
`define RI_SEL_BIT 8
`define IMM_HI 7
`define IMM_LO 0
`define RR_SECOND_HI 14
`define RR_SECOND_LO 12
`define RR_SECOND_SEL 12
`define RR_SECOND_SHORT_LO 13
`define RR_ZERO_BIT 11
`define RR_FIRST_HI 10
`define RR_FIRST_LO 8
`define RR_FIRST_SEL 8
`define RR_OPC_HI 7
`define RR_OPC_LO 0

// Short register fields address odd registers only
`define ODD_REG_LSB 1'b1
`define BRANCH_REG 3'h0

// Immediate-format opcodes (format bits 0 to 4)
`define RI_SUB_IMM 5'h14
`define RI_CMP_IMM 5'h16

// Register-format opcodes (format bits 8 to 15)
`define OPC_SUB_HALF 8'hA0
`define OPC_SUB_BYTE 8'h28
`define OPC_ADD_BYTE 8'h18
`define OPC_CMP_BYTE 8'h38
`define OPC_FULL_MASK 8'h08
`define OPC_CMP_MASK 8'h10

// Condition masks over the 24-bit aligned result
`define ZMASK_FULL 24'hFF_FFFF
`define ZMASK_HALF 24'h00_FFFF
`define ZMASK_BYTE0 24'h00_FF00

`endif

/* src/alu_pkg.sv */
// Types shared by the subtract and compare datapath
package alu_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_SUB_IMM,
        OP_SUB_FULL,
        OP_SUB_HALF,
        OP_SUB_BYTE,
        OP_ADD_BYTE,
        OP_CMP_IMM,
        OP_CMP_FULL,
        OP_CMP_HALF,
        OP_CMP_BYTE
    } op_t;

    typedef struct packed {
        op_t op;
        logic [2:0] first_operand_reg;
        logic [2:0] second_operand_reg;
        logic first_byte_select;
        logic second_byte_select;
        logic [7:0] imm;
    } decoded_t;

    typedef struct packed {
        logic [23:0] a;
        logic [23:0] b;
        logic subtract;
        logic wide;
        logic [23:0] zmask;
    } operands_t;

    typedef struct packed {
        logic [23:0] sum;
        logic carry;
        logic zero;
    } alu_res_t;

    typedef struct packed {
        logic valid;
        logic [2:0] addr;
        logic [23:0] data;
    } wb_t;

    typedef struct packed {
        logic valid;
        logic [23:0] addr;
    } branch_t;

endpackage : alu_pkg

/* src/arith_unit.sv */
// Aligned 24-bit add/subtract unit with carry and zero extraction
`timescale 1ns/100ps
`include "alu_cfg.svh"
module arith_unit (
    // Prepared operands
    input wire alu_pkg::operands_t ops,
    // Result and condition
    output alu_pkg::alu_res_t res
);

    // Ripple of one 16-bit slice, used for the low and high parts
    function automatic logic [16:0] sum17(input logic [15:0] x, input logic [15:0] y,
                                          input logic cin);
        sum17 = {1'b0, x} + {1'b0, y} + {16'h0000, cin};
    endfunction : sum17

    logic [23:0] b_eff;
    logic [16:0] low;
    logic [16:0] high;
    logic carry_out;

    // Subtraction adds the inverted operand plus one
    always_comb begin
        b_eff = ops.subtract ? ~ops.b : ops.b;
        low = sum17(ops.a[15:0], b_eff[15:0], ops.subtract);
        high = sum17({8'h00, ops.a[23:16]}, {8'h00, b_eff[23:16]}, low[16]);
        // Narrow forms sense the carry out of byte 0, so byte X never counts
        carry_out = ops.wide ? high[8] : low[16];
        res.sum = {high[7:0], low[15:0]};
        // A missing carry on subtract means a borrow: the result went negative
        res.carry = ops.subtract ? ~carry_out : carry_out;
        res.zero = ((res.sum & ops.zmask) == 24'h00_0000);
    end

endmodule : arith_unit

/* src/subtract_compare_alu.sv */
// Subtract, compare and add-byte execution datapath with condition latches
//
// Operation
// - add-byte wide: carry from byte 0, zero bytes 0-1
// - byte X computed but sets latches only in full forms
// - subtract immediate from byte 0 or halfword
// - short register fields address odd registers
// - short operand zero-extended before subtracting
// - subtract adds two's complement; negative stays complemented
// - immediate subtract: carry negative, zero equal
// - full subtract uses all three bytes
// - full subtract: carry negative, zero zero
// - halfword subtract excludes byte X, 16-bit flags
// - register 0 destination branches, latches kept
// - byte subtract from X0 or X01
// - subtract forms differ by opcode bit 12
// - compare forms differ by bit 12, bit 11 set
// - compare immediate alters neither operand
// - compares are unsigned over all bits
// - compare immediate: carry less, zero equal
// - full compare over three bytes
// - halfword compare over bytes 0 and 1
`timescale 1ns/100ps
`include "alu_cfg.svh"
module subtract_compare_alu (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Instruction issue
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    // Register file read ports, answered in the same cycle
    output logic [2:0] rd_first_addr,
    output logic [2:0] rd_second_addr,
    input wire logic [23:0] rd_first_data,
    input wire logic [23:0] rd_second_data,
    // Result write-back
    output alu_pkg::wb_t wb,
    // Condition latches
    output logic carry_latch,
    output logic zero_latch,
    // Branch request and decode error
    output alu_pkg::branch_t branch,
    output logic illegal_op
);

    // Odd register address from a two-bit field
    function automatic logic [2:0] odd_reg(input logic [1:0] field);
        odd_reg = {field, `ODD_REG_LSB};
    endfunction : odd_reg

    // Byte 0 sits above byte 1 inside the halfword
    function automatic logic [7:0] pick_byte(input logic [23:0] r, input logic sel);
        pick_byte = sel ? r[7:0] : r[15:8];
    endfunction : pick_byte

    // Place a byte at byte 0 (sel 0) or at byte 1 (sel 1), rest zero
    function automatic logic [23:0] align_byte(input logic [7:0] v, input logic sel);
        align_byte = sel ? {16'h0000, v} : {8'h00, v, 8'h00};
    endfunction : align_byte

    alu_pkg::decoded_t dec;
    alu_pkg::operands_t ops;
    alu_pkg::alu_res_t res;
    logic writes;
    logic keep_x;
    logic is_compare;
    logic to_branch;
    logic [7:0] rr_opc;

    // Decode the instruction word into operation and register fields
    always_comb begin
        rr_opc = instr[`RR_OPC_HI:`RR_OPC_LO];
        dec.op = alu_pkg::OP_NONE;
        dec.imm = instr[`IMM_HI:`IMM_LO];
        dec.first_byte_select = instr[`RR_FIRST_SEL];
        dec.second_byte_select = instr[`RR_SECOND_SEL];
        dec.first_operand_reg = instr[`RR_FIRST_HI:`RR_FIRST_LO];
        dec.second_operand_reg = instr[`RR_SECOND_HI:`RR_SECOND_LO];
        if (instr[`FMT_RI_BIT]) begin
            dec.first_operand_reg = odd_reg(instr[`RI_REG_HI:`RI_REG_LO]);
            dec.first_byte_select = instr[`RI_SEL_BIT];
            if (instr[`RI_OPC_HI:`RI_OPC_LO] == `RI_SUB_IMM) begin
                dec.op = alu_pkg::OP_SUB_IMM;
            end else if (instr[`RI_OPC_HI:`RI_OPC_LO] == `RI_CMP_IMM) begin
                dec.op = alu_pkg::OP_CMP_IMM;
            end
        end else if (!instr[`RR_ZERO_BIT]) begin
            // Full and halfword forms share a pattern, bit 12 picks the width
            unique case (rr_opc & ~`OPC_FULL_MASK)
                `OPC_SUB_HALF: begin
                    dec.op = (rr_opc & `OPC_FULL_MASK) != 8'h00 ?
                             alu_pkg::OP_SUB_FULL : alu_pkg::OP_SUB_HALF;
                end
                (`OPC_SUB_HALF | `OPC_CMP_MASK): begin
                    dec.op = (rr_opc & `OPC_FULL_MASK) != 8'h00 ?
                             alu_pkg::OP_CMP_FULL : alu_pkg::OP_CMP_HALF;
                end
                default: begin
                    dec.op = alu_pkg::OP_NONE;
                end
            endcase
            // Byte forms carry short register fields with select bits
            if (rr_opc == `OPC_SUB_BYTE || rr_opc == `OPC_ADD_BYTE ||
                rr_opc == `OPC_CMP_BYTE) begin
                dec.first_operand_reg = odd_reg(instr[`RR_FIRST_HI:`RI_REG_LO]);
                dec.second_operand_reg = odd_reg(instr[`RR_SECOND_HI:`RR_SECOND_SHORT_LO]);
                dec.op = rr_opc == `OPC_SUB_BYTE ? alu_pkg::OP_SUB_BYTE :
                         rr_opc == `OPC_ADD_BYTE ? alu_pkg::OP_ADD_BYTE :
                         alu_pkg::OP_CMP_BYTE;
            end
        end
    end

    // Register reads are driven straight from the decode
    assign rd_first_addr = dec.first_operand_reg;
    assign rd_second_addr = dec.second_operand_reg;

    // Align both operands so every narrow carry leaves bit 15
    always_comb begin
        ops.a = rd_first_data;
        ops.b = rd_second_data;
        ops.subtract = 1'b1;
        ops.wide = 1'b0;
        ops.zmask = `ZMASK_HALF;
        writes = 1'b0;
        keep_x = 1'b0;
        is_compare = 1'b0;
        unique case (dec.op)
            alu_pkg::OP_SUB_IMM: begin
                ops.b = align_byte(dec.imm, dec.first_byte_select);
                ops.zmask = dec.first_byte_select ? `ZMASK_HALF : `ZMASK_BYTE0;
                writes = 1'b1;
            end
            alu_pkg::OP_SUB_FULL: begin
                ops.wide = 1'b1;
                ops.zmask = `ZMASK_FULL;
                writes = 1'b1;
            end
            alu_pkg::OP_SUB_HALF: begin
                ops.b = {8'h00, rd_second_data[15:0]};
                writes = 1'b1;
                keep_x = 1'b1;
            end
            alu_pkg::OP_SUB_BYTE, alu_pkg::OP_ADD_BYTE: begin
                ops.b = align_byte(pick_byte(rd_second_data, dec.second_byte_select),
                                   dec.first_byte_select);
                ops.subtract = (dec.op == alu_pkg::OP_SUB_BYTE);
                ops.zmask = dec.first_byte_select ? `ZMASK_HALF : `ZMASK_BYTE0;
                writes = 1'b1;
            end
            alu_pkg::OP_CMP_IMM: begin
                // Both bytes compared as plain unsigned values
                ops.a = align_byte(pick_byte(rd_first_data, dec.first_byte_select),
                                   1'b0);
                ops.b = align_byte(dec.imm, 1'b0);
                ops.zmask = `ZMASK_BYTE0;
                is_compare = 1'b1;
            end
            alu_pkg::OP_CMP_FULL: begin
                ops.wide = 1'b1;
                ops.zmask = `ZMASK_FULL;
                is_compare = 1'b1;
            end
            alu_pkg::OP_CMP_HALF: begin
                ops.a = {8'h00, rd_first_data[15:0]};
                ops.b = {8'h00, rd_second_data[15:0]};
                is_compare = 1'b1;
            end
            alu_pkg::OP_CMP_BYTE: begin
                ops.a = align_byte(pick_byte(rd_first_data, dec.first_byte_select), 1'b0);
                ops.b = align_byte(pick_byte(rd_second_data, dec.second_byte_select),
                                   1'b0);
                ops.zmask = `ZMASK_BYTE0;
                is_compare = 1'b1;
            end
            alu_pkg::OP_NONE: begin
                writes = 1'b0;
            end
        endcase
    end

    // Shared adder; byte X rides along but is masked out of the flags except in the full forms
    arith_unit u_arith (
        .ops(ops),
        .res(res)
    );

    // Register 0 as destination of the full or halfword forms becomes a branch
    assign to_branch = dec.first_operand_reg == `BRANCH_REG &&
                       (dec.op == alu_pkg::OP_SUB_FULL || dec.op == alu_pkg::OP_SUB_HALF ||
                        dec.op == alu_pkg::OP_CMP_FULL || dec.op == alu_pkg::OP_CMP_HALF);

    alu_pkg::wb_t wb_r;
    alu_pkg::wb_t wb_nxt;
    alu_pkg::branch_t branch_r;
    alu_pkg::branch_t branch_nxt;
    logic carry_r;
    logic carry_nxt;
    logic zero_r;
    logic zero_nxt;
    logic illegal_r;
    logic illegal_nxt;

    // Next state of write-back, latches and branch
    always_comb begin
        wb_nxt.valid = 1'b0;
        wb_nxt.addr = dec.first_operand_reg;
        wb_nxt.data = keep_x ? {rd_first_data[23:16], res.sum[15:0]} : res.sum;
        branch_nxt.valid = 1'b0;
        // Subtracts branch to their result, compares to register 0 as it stands
        branch_nxt.addr = is_compare ? rd_first_data : wb_nxt.data;
        carry_nxt = carry_r;
        zero_nxt = zero_r;
        illegal_nxt = 1'b0;
        if (instr_valid) begin
            illegal_nxt = (dec.op == alu_pkg::OP_NONE);
            if (to_branch) begin
                branch_nxt.valid = 1'b1;
                wb_nxt.valid = !is_compare;
            end else if (dec.op != alu_pkg::OP_NONE) begin
                // Compares never write, so neither operand changes
                wb_nxt.valid = writes;
                carry_nxt = res.carry;
                zero_nxt = res.zero;
            end
        end
    end

    // Registered outputs; latches clear at reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wb_r <= '0;
            branch_r <= '0;
            carry_r <= 1'b0;
            zero_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            wb_r <= wb_nxt;
            branch_r <= branch_nxt;
            carry_r <= carry_nxt;
            zero_r <= zero_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    assign wb = wb_r;
    assign branch = branch_r;
    assign carry_latch = carry_r;
    assign zero_latch = zero_r;
    assign illegal_op = illegal_r;

    // Reference values that only the checks below read
    logic [16:0] chk_add16;
    logic [23:0] chk_diff;
    logic [7:0] chk_first_sel;

    always_comb begin
        chk_add16 = {1'b0, rd_first_data[15:0]} +
                    {9'h000, pick_byte(rd_second_data, dec.second_byte_select)};
        chk_diff = rd_first_data - rd_second_data;
        chk_first_sel = pick_byte(rd_first_data, dec.first_byte_select);
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_issue(alu_pkg::op_t o);
        instr_valid && dec.op == o && !to_branch;
    endsequence

    sequence s_wide_issue(alu_pkg::op_t o);
        s_issue(o) ##0 dec.first_byte_select;
    endsequence

    a_add_byte_flags: assert property (s_wide_issue(alu_pkg::OP_ADD_BYTE) |=>
        carry_latch == $past(chk_add16[16]) &&
        zero_latch == ($past(chk_add16[15:0]) == 16'h0000))
        else $error("add-byte latches wrong");

    a_byte_x_ignored: assert property (s_wide_issue(alu_pkg::OP_SUB_IMM) |=>
        zero_latch == ($past(rd_first_data[15:0]) == {8'h00, $past(dec.imm)}))
        else $error("byte X influenced zero latch");

    a_imm_sub_value: assert property (s_issue(alu_pkg::OP_SUB_IMM) |=>
        wb.valid && wb.data == $past(rd_first_data - align_byte(dec.imm,
        dec.first_byte_select)))
        else $error("immediate subtract result wrong");

    a_odd_reg_addr: assert property (instr_valid && (instr[`FMT_RI_BIT] ||
        dec.op == alu_pkg::OP_SUB_BYTE || dec.op == alu_pkg::OP_CMP_BYTE) |->
        rd_first_addr[0] && (instr[`FMT_RI_BIT] || rd_second_addr[0]))
        else $error("even register addressed by short field");

    a_imm_narrow_flags: assert property (s_issue(alu_pkg::OP_SUB_IMM) ##0
        !dec.first_byte_select |=>
        carry_latch == ($past(rd_first_data[15:8]) < $past(dec.imm)))
        else $error("immediate subtract carry wrong");

    a_full_sub: assert property (s_issue(alu_pkg::OP_SUB_FULL) |=>
        wb.data == $past(chk_diff) && zero_latch == ($past(chk_diff) == 24'h00_0000) &&
        carry_latch == ($past(rd_first_data) < $past(rd_second_data)))
        else $error("full subtract wrong");

    a_half_sub: assert property (s_issue(alu_pkg::OP_SUB_HALF) |=>
        wb.data[23:16] == $past(rd_first_data[23:16]) &&
        carry_latch == ($past(rd_first_data[15:0]) < $past(rd_second_data[15:0])))
        else $error("halfword subtract touched byte X");

    a_r0_branch: assert property (instr_valid && to_branch |=>
        branch.valid && $stable(carry_latch) && $stable(zero_latch))
        else $error("register 0 destination did not branch cleanly");

    a_byte_sub: assert property (s_wide_issue(alu_pkg::OP_SUB_BYTE) |=>
        wb.data == $past(rd_first_data - {16'h0000, pick_byte(rd_second_data,
        dec.second_byte_select)}))
        else $error("byte subtract result wrong");

    a_cmp_imm: assert property (s_issue(alu_pkg::OP_CMP_IMM) |=>
        !wb.valid && carry_latch == ($past(chk_first_sel) < $past(dec.imm)) &&
        zero_latch == ($past(chk_first_sel) == $past(dec.imm)))
        else $error("compare immediate latches wrong");

    a_cmp_full: assert property (s_issue(alu_pkg::OP_CMP_FULL) |=>
        !wb.valid && carry_latch == ($past(rd_first_data) < $past(rd_second_data)))
        else $error("full compare carry wrong");

    a_cmp_half: assert property (s_issue(alu_pkg::OP_CMP_HALF) |=>
        zero_latch == ($past(rd_first_data[15:0]) == $past(rd_second_data[15:0])))
        else $error("halfword compare zero wrong");

    a_latch_cause: assert property ($changed(carry_latch) || $changed(zero_latch) |->
        $past(instr_valid) && $past(dec.op) != alu_pkg::OP_NONE && !$past(to_branch))
        else $error("latch changed without an executed instruction");

endmodule : subtract_compare_alu

/* testbench/reg_file_model.sv */
// Register file model that answers the datapath's operand reads
`timescale 1ns/100ps
module reg_file_model (
    // Clock
    input wire logic clk_sys,
    // Read ports
    input wire logic [2:0] rd_first_addr,
    input wire logic [2:0] rd_second_addr,
    output logic [23:0] rd_first_data,
    output logic [23:0] rd_second_data,
    // Write-back from the datapath
    input wire alu_pkg::wb_t wb,
    // Preload from the bench
    input wire logic load_en,
    input wire logic [2:0] load_addr,
    input wire logic [23:0] load_data
);
    logic [23:0] regs [0:7];

    // Known contents from time zero
    initial begin
        for (int i = 0; i < 8; i++) begin
            regs[i] = 24'h00_0000;
        end
    end

    // Writes land at the edge that ends the write-back pulse
    always @(posedge clk_sys) begin
        if (wb.valid) begin
            regs[wb.addr] <= wb.data;
        end
        if (load_en) begin
            regs[load_addr] <= load_data;
        end
    end

    // Pending write-back is forwarded, since the datapath has no bypass of its own
    always_comb begin
        rd_first_data = regs[rd_first_addr];
        rd_second_data = regs[rd_second_addr];
        if (wb.valid && wb.addr == rd_first_addr) begin
            rd_first_data = wb.data;
        end
        if (wb.valid && wb.addr == rd_second_addr) begin
            rd_second_data = wb.data;
        end
    end
endmodule : reg_file_model

/* testbench/subtract_compare_alu_tb_top.sv */
// Self-checking bench for the subtract and compare datapath
`timescale 1ns/100ps
module subtract_compare_alu_tb_top;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic instr_valid = 1'h0;
    logic [15:0] instr = 16'h0000;
    logic [2:0] rd_first_addr;
    logic [2:0] rd_second_addr;
    logic [23:0] rd_first_data;
    logic [23:0] rd_second_data;
    alu_pkg::wb_t wb;
    logic carry_latch;
    logic zero_latch;
    alu_pkg::branch_t branch;
    logic illegal_op;
    logic load_en = 1'h0;
    logic [2:0] load_addr = 3'h0;
    logic [23:0] load_data = 24'h00_0000;
    int n_errors = 0;
    int comparisons = 0;

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    subtract_compare_alu dut (
        .clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .rd_first_addr(rd_first_addr), .rd_second_addr(rd_second_addr),
        .rd_first_data(rd_first_data), .rd_second_data(rd_second_data), .wb(wb),
        .carry_latch(carry_latch), .zero_latch(zero_latch), .branch(branch),
        .illegal_op(illegal_op)
    );

    reg_file_model regs_u (
        .clk_sys(clk_sys), .rd_first_addr(rd_first_addr), .rd_second_addr(rd_second_addr),
        .rd_first_data(rd_first_data), .rd_second_data(rd_second_data), .wb(wb),
        .load_en(load_en), .load_addr(load_addr), .load_data(load_data)
    );

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_addr(input string what, input logic [2:0] exp, input logic [2:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_addr

    task automatic chk_word(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word

    // Preload one register; the model writes it at the second edge
    task automatic set_reg(input logic [2:0] a, input logic [23:0] d);
        @(posedge clk_sys);
        load_en <= 1'h1;
        load_addr <= a;
        load_data <= d;
        @(posedge clk_sys);
        load_en <= 1'h0;
    endtask : set_reg

    // Outputs one cycle after the instruction was taken; d is data or branch target
    task automatic chk_result(input logic [2:0] a1, input logic wv, input logic [23:0] d,
            input logic c, input logic z, input logic bv, input logic il);
        chk_bit("write-back valid", wv, wb.valid);
        if (wv) begin
            chk_addr("write-back address", a1, wb.addr);
            chk_word("write-back data", d, wb.data);
        end
        chk_bit("carry latch", c, carry_latch);
        chk_bit("zero latch", z, zero_latch);
        chk_bit("branch valid", bv, branch.valid);
        if (bv) begin
            chk_word("branch address", d, branch.addr);
        end
        chk_bit("illegal op", il, illegal_op);
    endtask : chk_result

    // One instruction, then its answer and the end of the write-back pulse; a2 of 0 skips that check
    task automatic exec(input logic [15:0] w, input logic [2:0] a1, input logic [2:0] a2,
            input logic wv, input logic [23:0] d, input logic c, input logic z,
            input logic bv, input logic il);
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr <= w;
        #1;
        chk_addr("first read address", a1, rd_first_addr);
        if (a2 != 3'h0) begin
            chk_addr("second read address", a2, rd_second_addr);
        end
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        #1;
        chk_result(a1, wv, d, c, z, bv, il);
        @(posedge clk_sys);
        #1;
        chk_bit("write-back pulse end", 1'h0, wb.valid);
    endtask : exec

    task automatic t_reset;
        @(posedge clk_sys);
        #1;
        chk_result(3'h0, 1'h0, 24'h00_0000, 1'h0, 1'h0, 1'h0, 1'h0);
        $display("reset test done");
    endtask : t_reset

    // Immediate subtract on byte 0 and on the halfword, byte X carried along
    task automatic t_sub_imm;
        set_reg(3'h3, 24'h12_0540);
        set_reg(3'h5, 24'h01_0700);
        set_reg(3'h7, 24'h01_0010);
        exec(16'hA206, 3'h3, 3'h0, 1'h1, 24'h11_FF40, 1'h1, 1'h0, 1'h0, 1'h0);
        exec(16'hA340, 3'h3, 3'h0, 1'h1, 24'h11_FF00, 1'h0, 1'h0, 1'h0, 1'h0);
        exec(16'hA407, 3'h5, 3'h0, 1'h1, 24'h01_0000, 1'h0, 1'h1, 1'h0, 1'h0);
        exec(16'hA720, 3'h7, 3'h0, 1'h1, 24'h00_FFF0, 1'h1, 1'h0, 1'h0, 1'h0);
        $display("immediate subtract test done");
    endtask : t_sub_imm

    // Full and halfword register subtract, told apart by one opcode bit
    task automatic t_sub_reg;
        set_reg(3'h3, 24'h00_0010);
        set_reg(3'h5, 24'h00_0020);
        exec(16'h53A8, 3'h3, 3'h5, 1'h1, 24'hFF_FFF0, 1'h1, 1'h0, 1'h0, 1'h0);
        set_reg(3'h3, 24'h01_0000);
        set_reg(3'h5, 24'h00_0001);
        exec(16'h53A8, 3'h3, 3'h5, 1'h1, 24'h00_FFFF, 1'h0, 1'h0, 1'h0, 1'h0);
        set_reg(3'h3, 24'h01_0000);
        exec(16'h53A0, 3'h3, 3'h5, 1'h1, 24'h01_FFFF, 1'h1, 1'h0, 1'h0, 1'h0);
        set_reg(3'h1, 24'h05_1234);
        set_reg(3'h7, 24'h09_1234);
        exec(16'h71A0, 3'h1, 3'h7, 1'h1, 24'h05_0000, 1'h0, 1'h1, 1'h0, 1'h0);
        set_reg(3'h1, 24'h09_1234);
        exec(16'h71A8, 3'h1, 3'h7, 1'h1, 24'h00_0000, 1'h0, 1'h1, 1'h0, 1'h0);
        $display("register subtract test done");
    endtask : t_sub_reg

    // Byte subtract with both select settings, add-byte with select bits 1 only
    task automatic t_byte_ops;
        set_reg(3'h3, 24'h10_0055);
        set_reg(3'h5, 24'h00_AA33);
        exec(16'h5228, 3'h3, 3'h5, 1'h1, 24'h0F_CD55, 1'h1, 1'h0, 1'h0, 1'h0);
        exec(16'h4328, 3'h3, 3'h5, 1'h1, 24'h0F_CCAB, 1'h0, 1'h0, 1'h0, 1'h0);
        set_reg(3'h1, 24'h00_FFD0);
        set_reg(3'h7, 24'h10_2030);
        exec(16'h7118, 3'h1, 3'h7, 1'h1, 24'h01_0000, 1'h1, 1'h1, 1'h0, 1'h0);
        $display("byte operation test done");
    endtask : t_byte_ops

    // All compare forms: unsigned, no write-back
    task automatic t_compare;
        set_reg(3'h3, 24'hFF_8040);
        exec(16'hB27F, 3'h3, 3'h0, 1'h0, 24'h00_0000, 1'h0, 1'h0, 1'h0, 1'h0);
        exec(16'hB340, 3'h3, 3'h0, 1'h0, 24'h00_0000, 1'h0, 1'h1, 1'h0, 1'h0);
        exec(16'hB341, 3'h3, 3'h0, 1'h0, 24'h00_0000, 1'h1, 1'h0, 1'h0, 1'h0);
        set_reg(3'h3, 24'h00_0001);
        set_reg(3'h5, 24'h80_0000);
        exec(16'h53B8, 3'h3, 3'h5, 1'h0, 24'h00_0000, 1'h1, 1'h0, 1'h0, 1'h0);
        exec(16'h53B0, 3'h3, 3'h5, 1'h0, 24'h00_0000, 1'h0, 1'h0, 1'h0, 1'h0);
        exec(16'h5238, 3'h3, 3'h5, 1'h0, 24'h00_0000, 1'h0, 1'h1, 1'h0, 1'h0);
        $display("compare test done");
    endtask : t_compare

    // Register 0 as destination branches and keeps the latches (carry 1, zero 0)
    task automatic t_branch;
        set_reg(3'h0, 24'h00_0100);
        set_reg(3'h3, 24'h00_0001);
        set_reg(3'h5, 24'h00_0020);
        exec(16'h53B8, 3'h3, 3'h5, 1'h0, 24'h00_0000, 1'h1, 1'h0, 1'h0, 1'h0);
        exec(16'h50A8, 3'h0, 3'h5, 1'h1, 24'h00_00E0, 1'h1, 1'h0, 1'h1, 1'h0);
        exec(16'h50B0, 3'h0, 3'h5, 1'h0, 24'h00_00E0, 1'h1, 1'h0, 1'h1, 1'h0);
        exec(16'h50A0, 3'h0, 3'h5, 1'h1, 24'h00_00C0, 1'h1, 1'h0, 1'h1, 1'h0);
        $display("branch test done");
    endtask : t_branch

    // Unknown words leave registers and latches alone
    task automatic t_illegal;
        exec(16'h5355, 3'h3, 3'h5, 1'h0, 24'h00_0000, 1'h1, 1'h0, 1'h0, 1'h1);
        exec(16'h5BA8, 3'h3, 3'h0, 1'h0, 24'h00_0000, 1'h1, 1'h0, 1'h0, 1'h1);
        $display("illegal word test done");
    endtask : t_illegal

    // Two dependent subtracts issued in consecutive cycles
    task automatic t_back_to_back;
        set_reg(3'h3, 24'h00_0005);
        set_reg(3'h5, 24'h00_0001);
        @(posedge clk_sys);
        instr_valid <= 1'h1;
        instr <= 16'h53A8;
        @(posedge clk_sys);
        #1;
        chk_result(3'h3, 1'h1, 24'h00_0004, 1'h0, 1'h0, 1'h0, 1'h0);
        @(posedge clk_sys);
        instr_valid <= 1'h0;
        #1;
        chk_result(3'h3, 1'h1, 24'h00_0003, 1'h0, 1'h0, 1'h0, 1'h0);
        $display("back to back test done");
    endtask : t_back_to_back

    // Main sequence: reset held for two cycles, then every scenario
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        t_reset;
        t_sub_imm;
        t_sub_reg;
        t_byte_ops;
        t_compare;
        t_branch;
        t_illegal;
        t_back_to_back;
        complete_run;
    end

    // Bounded run time so a hang still reaches the verdict
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        $display("CHECK FAILED run length expected under 5000 cycles seen 5000");
        complete_run;
    end
endmodule : subtract_compare_alu_tb_top
